// file: pkg/acq_ctrl_pkg.sv
// Purpose: constants and types for the acquisition mode and analog control bank
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes:   printed offsets are register indices; byte address is index times four
package acq_ctrl_pkg;
  // ==========================================================
  // register indices
  localparam logic [5:0] IDX_DROP_HI   = 6'h0F;
  localparam logic [5:0] IDX_DROP_LO   = 6'h10;
  localparam logic [5:0] IDX_THR_HI    = 6'h11;
  localparam logic [5:0] IDX_THR_LO    = 6'h12;
  localparam logic [5:0] IDX_AMP_GAIN  = 6'h13;
  localparam logic [5:0] IDX_PD_ONE    = 6'h14;
  localparam logic [5:0] IDX_IRQ_STAT  = 6'h18;
  localparam logic [5:0] IDX_IRQ_MASK  = 6'h19;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_BYTE_ZERO = 8'h00;
  localparam logic [7:0] RST_AMP_GAIN  = 8'h50;
  localparam logic [7:0] RST_PD_ONE    = 8'hCF;
  // ==========================================================
  // field layout
  localparam int         AMP_CUR_LSB   = 6;
  localparam int         AMP_VOLT_LSB  = 4;
  localparam logic [7:0] AMP_RW_MASK   = 8'hF0;
  localparam logic [7:0] PD_RW_MASK    = 8'hCF;
  localparam int         IRQ_DROP_BIT  = 0;
  localparam int         IRQ_THR_BIT   = 1;
  localparam logic [1:0] IRQ_RW_MASK   = 2'h3;
  // ==========================================================
  // bus responses
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    DROP_IDLE  = 2'b00,
    DROP_COUNT = 2'b01,
    DROP_ARMED = 2'b11
  } drop_state_e;

  typedef struct packed {
    logic [1:0] cur_gain;
    logic [1:0] volt_gain;
    logic       chop_cur_en;
    logic       chop_volt_en;
    logic       cur_amp_en;
    logic       cur_mod_en;
    logic       volt_amp_en;
    logic       volt_mod_en;
  } analog_ctrl_s;
endpackage

// file: rtl/acq_mode_analog_ctrl_regs.sv
// Purpose: drop count, threshold, gain and power-down control bank on AXI4-Lite
// Assumes: mode and sample inputs come from logic on sys_clk
// Notes:   16-bit values reach the block only once both bytes are written
`timescale 1ns/10ps
module acq_mode_analog_ctrl_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic                      sys_clk,
  input  wire logic                      nrst,
  input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [ADDR_W-1:0]         s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      second_normal_mode,
  input  wire logic                      sample_valid,
  input  wire logic [15:0]               current_sample,
  output acq_ctrl_pkg::analog_ctrl_s     analog_ctrl,
  output logic [15:0]                    sample_drop_count,
  output logic [15:0]                    current_threshold,
  output logic                           irq
);
  import acq_ctrl_pkg::*;

  // ==========================================================
  // decode
  function automatic logic idx_mapped(input logic [5:0] idx);
    idx_mapped = (idx >= IDX_DROP_HI && idx <= IDX_PD_ONE) ||
                 idx == IDX_IRQ_STAT || idx == IDX_IRQ_MASK;
  endfunction

  logic              aw_held_reg;
  logic [5:0]        aw_idx_reg;
  logic              w_held_reg;
  logic [7:0]        w_byte_reg;
  logic              w_lane_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       rdata_reg;
  logic [7:0]        drop_hi_reg;
  logic [7:0]        drop_lo_reg;
  logic [7:0]        thr_hi_reg;
  logic [7:0]        thr_lo_reg;
  logic [7:0]        amp_reg;
  logic [7:0]        pd_reg;
  logic [1:0]        stat_reg;
  logic [1:0]        mask_reg;
  logic              drop_hi_wr_reg;
  logic              drop_lo_wr_reg;
  logic              thr_hi_wr_reg;
  logic              thr_lo_wr_reg;
  logic [15:0]       drop_act_reg;
  logic [15:0]       thr_act_reg;
  logic [15:0]       dropped_reg;
  drop_state_e       state_reg;
  drop_state_e       state_next;

  wire               aw_fire  = s_axi_awvalid & s_axi_awready;
  wire               w_fire   = s_axi_wvalid & s_axi_wready;
  wire               ar_fire  = s_axi_arvalid & s_axi_arready;
  wire [5:0]         wr_idx   = aw_held_reg ? aw_idx_reg : s_axi_awaddr[7:2];
  wire [7:0]         wr_byte  = w_held_reg ? w_byte_reg : s_axi_wdata[7:0];
  wire               wr_lane  = w_held_reg ? w_lane_reg : s_axi_wstrb[0];
  wire               wr_go    = (aw_held_reg | aw_fire) & (w_held_reg | w_fire) & ~bvalid_reg;
  wire               wr_ok    = wr_go & wr_lane & idx_mapped(wr_idx);
  wire               wr_dhi   = wr_ok & (wr_idx == IDX_DROP_HI);
  wire               wr_dlo   = wr_ok & (wr_idx == IDX_DROP_LO);
  wire               wr_thi   = wr_ok & (wr_idx == IDX_THR_HI);
  wire               wr_tlo   = wr_ok & (wr_idx == IDX_THR_LO);
  wire               wr_amp   = wr_ok & (wr_idx == IDX_AMP_GAIN);
  wire               wr_pd    = wr_ok & (wr_idx == IDX_PD_ONE);
  wire               wr_stat  = wr_ok & (wr_idx == IDX_IRQ_STAT);
  wire               wr_mask  = wr_ok & (wr_idx == IDX_IRQ_MASK);
  wire [5:0]         rd_idx   = s_axi_araddr[7:2];

  // pairing: both bytes seen, counting the byte written this cycle
  wire               drop_pair = (drop_hi_wr_reg | wr_dhi) & (drop_lo_wr_reg | wr_dlo);
  wire               thr_pair  = (thr_hi_wr_reg | wr_thi) & (thr_lo_wr_reg | wr_tlo);
  wire [7:0]         drop_hi_v = wr_dhi ? wr_byte : drop_hi_reg;
  wire [7:0]         drop_lo_v = wr_dlo ? wr_byte : drop_lo_reg;
  wire [7:0]         thr_hi_v  = wr_thi ? wr_byte : thr_hi_reg;
  wire [7:0]         thr_lo_v  = wr_tlo ? wr_byte : thr_lo_reg;

  // ==========================================================
  // read mux
  logic [7:0] rd_byte;
  always_comb begin
    case (rd_idx)
      IDX_DROP_HI:  rd_byte = drop_hi_reg;
      IDX_DROP_LO:  rd_byte = drop_lo_reg;
      IDX_THR_HI:   rd_byte = thr_hi_reg;
      IDX_THR_LO:   rd_byte = thr_lo_reg;
      IDX_AMP_GAIN: rd_byte = amp_reg & AMP_RW_MASK;
      IDX_PD_ONE:   rd_byte = pd_reg & PD_RW_MASK;
      IDX_IRQ_STAT: rd_byte = {6'h00, stat_reg};
      IDX_IRQ_MASK: rd_byte = {6'h00, mask_reg};
      default:      rd_byte = 8'h00;
    endcase
  end

  // ==========================================================
  // bus handshake
  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      aw_held_reg <= 1'b0;
      aw_idx_reg  <= 6'h00;
      w_held_reg  <= 1'b0;
      w_byte_reg  <= 8'h00;
      w_lane_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (aw_fire && !wr_go) begin
        aw_held_reg <= 1'b1;
        aw_idx_reg  <= s_axi_awaddr[7:2];
      end else if (wr_go) begin
        aw_held_reg <= 1'b0;
      end
      if (w_fire && !wr_go) begin
        w_held_reg <= 1'b1;
        w_byte_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_held_reg <= 1'b0;
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= idx_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      rdata_reg  <= {24'h00_0000, rd_byte};
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // byte registers, reset
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      drop_hi_reg <= RST_BYTE_ZERO;
      drop_lo_reg <= RST_BYTE_ZERO;
      thr_hi_reg  <= RST_BYTE_ZERO;
      thr_lo_reg  <= RST_BYTE_ZERO;
      amp_reg     <= RST_AMP_GAIN;
      pd_reg      <= RST_PD_ONE;
      mask_reg    <= 2'h0;
    end else begin
      drop_hi_reg <= drop_hi_v;
      drop_lo_reg <= drop_lo_v;
      thr_hi_reg  <= thr_hi_v;
      thr_lo_reg  <= thr_lo_v;
      if (wr_amp) amp_reg  <= wr_byte & AMP_RW_MASK;
      if (wr_pd)  pd_reg   <= wr_byte & PD_RW_MASK;
      if (wr_mask) mask_reg <= wr_byte[1:0] & IRQ_RW_MASK;
    end
  end

  // ==========================================================
  // paired 16-bit values
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      drop_hi_wr_reg <= 1'b0;
      drop_lo_wr_reg <= 1'b0;
      thr_hi_wr_reg  <= 1'b0;
      thr_lo_wr_reg  <= 1'b0;
      drop_act_reg   <= {RST_BYTE_ZERO, RST_BYTE_ZERO};
      thr_act_reg    <= {RST_BYTE_ZERO, RST_BYTE_ZERO};
    end else begin
      drop_hi_wr_reg <= drop_pair ? 1'b0 : (drop_hi_wr_reg | wr_dhi);
      drop_lo_wr_reg <= drop_pair ? 1'b0 : (drop_lo_wr_reg | wr_dlo);
      thr_hi_wr_reg  <= thr_pair ? 1'b0 : (thr_hi_wr_reg | wr_thi);
      thr_lo_wr_reg  <= thr_pair ? 1'b0 : (thr_lo_wr_reg | wr_tlo);
      if (drop_pair) drop_act_reg <= {drop_hi_v, drop_lo_v};
      if (thr_pair)  thr_act_reg  <= {thr_hi_v, thr_lo_v};
    end
  end

  // ==========================================================
  // sample drop sequence in second normal mode
  wire drop_done = (state_reg == DROP_COUNT) & sample_valid &
                   (dropped_reg == drop_act_reg);
  wire thr_hit   = (state_reg == DROP_ARMED) & sample_valid &
                   (current_sample >= thr_act_reg);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DROP_IDLE:  if (second_normal_mode) state_next = DROP_COUNT;
      DROP_COUNT: if (!second_normal_mode) state_next = DROP_IDLE;
                  else if (drop_done) state_next = DROP_ARMED;
      DROP_ARMED: if (!second_normal_mode) state_next = DROP_IDLE;
      default:    state_next = DROP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_reg   <= DROP_IDLE;
      dropped_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      // counter saturates: a count changed downward mid-run cannot wrap past it
      if (state_reg != DROP_COUNT)
        dropped_reg <= 16'h0000;
      else if (sample_valid && !drop_done && dropped_reg != 16'hFFFF)
        dropped_reg <= dropped_reg + 16'h0001;
    end
  end

  // ==========================================================
  // interrupt status, set wins over write-one-clear
  logic [1:0] events;
  assign events[IRQ_DROP_BIT] = drop_done;
  assign events[IRQ_THR_BIT]  = thr_hit;
  wire  [1:0] stat_clr = wr_stat ? wr_byte[1:0] : 2'h0;

  always_ff @(posedge sys_clk) begin
    if (!nrst) stat_reg <= 2'h0;
    else       stat_reg <= (stat_reg & ~stat_clr) | events;
  end

  assign irq = |(stat_reg & mask_reg);

  // ==========================================================
  // outputs
  assign analog_ctrl.cur_gain     = amp_reg[AMP_CUR_LSB +: 2];
  assign analog_ctrl.volt_gain    = amp_reg[AMP_VOLT_LSB +: 2];
  assign analog_ctrl.chop_cur_en  = pd_reg[7];
  assign analog_ctrl.chop_volt_en = pd_reg[6];
  assign analog_ctrl.cur_amp_en   = pd_reg[3];
  assign analog_ctrl.cur_mod_en   = pd_reg[2];
  assign analog_ctrl.volt_amp_en  = pd_reg[1];
  assign analog_ctrl.volt_mod_en  = pd_reg[0];
  assign sample_drop_count        = drop_act_reg;
  assign current_threshold        = thr_act_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_drop_event;
    drop_done |-> dropped_reg == sample_drop_count && state_reg == DROP_COUNT
                  ##1 stat_reg[IRQ_DROP_BIT] && state_reg != DROP_COUNT;
  endproperty
  a_drop_event: assert property (p_drop_event) else $error("drop end wrong");

  property p_thr_event;
    thr_hit |-> current_sample >= current_threshold ##1 stat_reg[IRQ_THR_BIT];
  endproperty
  a_thr_event: assert property (p_thr_event) else $error("threshold event wrong");

  property p_cur_gain;
    wr_amp |=> analog_ctrl.cur_gain == $past(wr_byte[7:6]);
  endproperty
  a_cur_gain: assert property (p_cur_gain) else $error("current gain not taken");

  property p_amp_rsv;
    ar_fire && rd_idx == IDX_AMP_GAIN |=> s_axi_rdata[3:0] == 4'h0 &&
      s_axi_rdata[5:4] == $past(analog_ctrl.volt_gain);
  endproperty
  a_amp_rsv: assert property (p_amp_rsv) else $error("gain readback wrong");

  property p_pd_bits;
    wr_pd |=> {analog_ctrl.chop_cur_en, analog_ctrl.chop_volt_en,
               analog_ctrl.cur_amp_en, analog_ctrl.cur_mod_en,
               analog_ctrl.volt_amp_en, analog_ctrl.volt_mod_en} ==
              {$past(wr_byte[7:6]), $past(wr_byte[3:0])};
  endproperty
  a_pd_bits: assert property (p_pd_bits) else $error("power-down bits wrong");

  property p_pd_rsv;
    ar_fire && rd_idx == IDX_PD_ONE |=> s_axi_rdata[5:4] == 2'h0 &&
      s_axi_rdata[0] == $past(analog_ctrl.volt_mod_en);
  endproperty
  a_pd_rsv: assert property (p_pd_rsv) else $error("power-down readback wrong");

  property p_reset_vals;
    disable iff (1'b0)
    $past(!nrst) |-> pd_reg == 8'hCF && amp_reg == 8'h50 &&
                     sample_drop_count == 16'h0000 && current_threshold == 16'h0000;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  property p_half_write;
    wr_dhi && !drop_lo_wr_reg |=> $stable(sample_drop_count);
  endproperty
  a_half_write: assert property (p_half_write) else $error("half value applied");

  property p_pair_apply;
    wr_tlo && thr_hi_wr_reg |=> current_threshold == {thr_hi_reg, thr_lo_reg};
  endproperty
  a_pair_apply: assert property (p_pair_apply) else $error("pair not applied");

  property p_irq_mask;
    events[IRQ_DROP_BIT] && mask_reg[IRQ_DROP_BIT] && !wr_mask |=> irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq missing");

  c_drop_done:  cover property (drop_done);
  c_thr_hit:    cover property (thr_hit ##1 irq);
  c_pair:       cover property (wr_dhi ##[1:20] wr_dlo);
  c_split_wr:   cover property (aw_fire && !w_fire ##[1:5] wr_go);
endmodule

// file: verification/conv_sample_source.sv
// Purpose: converter side model that feeds mode and current samples
// Assumes: one sample pulse per send call, all on sys_clk
// Notes:   data lines show the inverted last value between samples
`timescale 1ns/10ps
module conv_sample_source (
  input  wire logic        sys_clk,
  output logic             second_normal_mode,
  output logic             sample_valid,
  output logic [15:0]      current_sample
);
  // ==========================================
  // idle levels
  initial begin
    second_normal_mode = 1'b0;
    sample_valid       = 1'b0;
    current_sample     = 16'h0000;
  end
  // ==========================================
  // stimulus tasks
  task automatic set_mode(input logic m);
    @(posedge sys_clk);
    second_normal_mode <= m;
  endtask

  task automatic send(input logic [15:0] v);
    @(posedge sys_clk);
    sample_valid   <= 1'b1;
    current_sample <= v;
    @(posedge sys_clk);
    sample_valid   <= 1'b0;
    // stale data is not held, so a late read would see garbage
    current_sample <= ~v;
  endtask
endmodule

// file: verification/acq_mode_analog_ctrl_regs_bench.sv
// Purpose: self-checking bench for the acquisition and analog control bank
// Assumes: AXI4-Lite master tasks, handshakes judged before each rising edge
// Notes:   expected values come from the register table, not the design
`timescale 1ns/10ps
module acq_mode_analog_ctrl_regs_bench;
  import acq_ctrl_pkg::*;
  // ==========================================
  // signals
  logic         sys_clk, nrst;
  logic [7:0]   s_axi_awaddr, s_axi_araddr;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0]  s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic         s_axi_rvalid, s_axi_rready, second_normal_mode, sample_valid, irq;
  logic [15:0]  current_sample, sample_drop_count, current_threshold;
  analog_ctrl_s analog_ctrl;
  int           n_fail, samples_checked;
  logic [7:0]   exp_rst [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h50, 8'hCF};

  always #2 sys_clk = ~sys_clk;

  acq_mode_analog_ctrl_regs #(.ADDR_W(8)) u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .second_normal_mode(second_normal_mode),
    .sample_valid(sample_valid), .current_sample(current_sample),
    .analog_ctrl(analog_ctrl), .sample_drop_count(sample_drop_count),
    .current_threshold(current_threshold), .irq(irq));

  conv_sample_source u_conv (
    .sys_clk(sys_clk), .second_normal_mode(second_normal_mode),
    .sample_valid(sample_valid), .current_sample(current_sample));
  // ==========================================
  // compare and report
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch resp t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================
  // bus tasks, ready judged at the falling edge before the taking edge
  task automatic axi_wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er,
                        input logic [3:0] st = 4'hF);
    logic aw_p, w_p, ta, tw, b;
    logic [1:0] r;
    aw_p = 1'b1;
    w_p = 1'b1;
    b = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_awvalid <= 1'b1;
    // upper lanes carry junk that the bank must ignore
    s_axi_wdata   <= {24'hA5A5A5, d};
    s_axi_wstrb   <= st;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (aw_p || w_p) begin
      @(negedge sys_clk);
      ta = aw_p && (s_axi_awready === 1'b1);
      tw = w_p && (s_axi_wready === 1'b1);
      @(posedge sys_clk);
      aw_p = aw_p && !ta;
      w_p  = w_p && !tw;
      // each valid holds until its own ready was seen, then drops
      s_axi_awvalid <= aw_p;
      s_axi_wvalid  <= w_p;
    end
    while (!b) begin
      @(negedge sys_clk);
      b = (s_axi_bvalid === 1'b1);
      r = s_axi_bresp;
      @(posedge sys_clk);
    end
    s_axi_bready <= 1'b0;
    chk_resp(r, er);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] ev, input logic [1:0] er);
    logic t, b;
    logic [1:0] r;
    t = 1'b0;
    b = 1'b0;
    @(posedge sys_clk);
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!t) begin
      @(negedge sys_clk);
      t = (s_axi_arready === 1'b1);
      @(posedge sys_clk);
    end
    s_axi_arvalid <= 1'b0;
    while (!b) begin
      @(negedge sys_clk);
      b = (s_axi_rvalid === 1'b1);
      rd_data = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
    end
    s_axi_rready <= 1'b0;
    chk_val(rd_data, ev);
    chk_resp(r, er);
  endtask

  // status lands the cycle after the sample edge
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  // ==========================================
  // watchdog, tests need under three hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    report_and_stop();
  end
  // ==========================================
  // tests
  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    n_fail = 0;
    samples_checked = 0;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd_chk(IDX_DROP_HI + 6'(i), {24'h0, exp_rst[i]}, RESP_OKAY);
    end
    chk_val(32'(analog_ctrl), 32'h0000017F);
    $display("test reset done");
    for (int g = 0; g < 4; g++) begin
      axi_wr(IDX_AMP_GAIN, {2'(g), 2'(3 - g), 4'hF}, RESP_OKAY);
      rd_chk(IDX_AMP_GAIN, {24'h0, 2'(g), 2'(3 - g), 4'h0}, RESP_OKAY);
      chk_val({30'h0, analog_ctrl.cur_gain}, 32'(g));
      chk_val({30'h0, analog_ctrl.volt_gain}, 32'(3 - g));
    end
    // lane 0 strobe low: write answered but ignored
    axi_wr(IDX_AMP_GAIN, 8'h00, RESP_OKAY, 4'h0);
    rd_chk(IDX_AMP_GAIN, 32'hC0, RESP_OKAY);
    chk_val({30'h0, analog_ctrl.cur_gain}, 32'h3);
    $display("test gain done");
    for (int i = 0; i < 8; i++) begin
      axi_wr(IDX_PD_ONE, 8'h01 << i, RESP_OKAY);
      rd_chk(IDX_PD_ONE, (32'h01 << i) & 32'hCF, RESP_OKAY);
      chk_val({26'h0, analog_ctrl[5:0]}, 32'(((8'h01 << i) & 8'hC0) >> 2)
              | 32'((8'h01 << i) & 8'h0F));
    end
    $display("test power down done");
    axi_wr(IDX_THR_HI, 8'h12, RESP_OKAY);
    chk_val({16'h0, current_threshold}, 32'h0);
    rd_chk(IDX_THR_HI, 32'h12, RESP_OKAY);
    axi_wr(IDX_THR_LO, 8'h34, RESP_OKAY);
    chk_val({16'h0, current_threshold}, 32'h1234);
    axi_wr(IDX_DROP_LO, 8'h03, RESP_OKAY);
    chk_val({16'h0, sample_drop_count}, 32'h0);
    axi_wr(IDX_DROP_HI, 8'h00, RESP_OKAY);
    chk_val({16'h0, sample_drop_count}, 32'h3);
    axi_wr(6'h00, 8'hFF, RESP_SLVERR);
    rd_chk(6'h00, 32'h0, RESP_SLVERR);
    $display("test pairing done");
    axi_wr(IDX_IRQ_MASK, 8'h03, RESP_OKAY);
    u_conv.set_mode(1'b1);
    repeat (3) u_conv.send(16'hFFFF);
    settle();
    chk_val({31'h0, irq}, 32'h0);
    u_conv.send(16'h0000);
    settle();
    chk_val({31'h0, irq}, 32'h1);
    rd_chk(IDX_IRQ_STAT, 32'h1, RESP_OKAY);
    u_conv.send(16'h1233);
    settle();
    rd_chk(IDX_IRQ_STAT, 32'h1, RESP_OKAY);
    u_conv.send(16'h1234);
    settle();
    rd_chk(IDX_IRQ_STAT, 32'h3, RESP_OKAY);
    axi_wr(IDX_IRQ_STAT, 8'h01, RESP_OKAY);
    rd_chk(IDX_IRQ_STAT, 32'h2, RESP_OKAY);
    axi_wr(IDX_IRQ_MASK, 8'h01, RESP_OKAY);
    chk_val({31'h0, irq}, 32'h0);
    axi_wr(IDX_IRQ_STAT, 8'h02, RESP_OKAY);
    rd_chk(IDX_IRQ_STAT, 32'h0, RESP_OKAY);
    u_conv.set_mode(1'b0);
    $display("test interrupt done");
    report_and_stop();
  end
endmodule
